// ---- alc_loop.sv ----
// How it works
// - Brightening raises exposure first; gain only once exposure sits at its ceiling.
// - Metering area: full, centred 80% per axis, or centred 40% per axis.
// - Target luminance 0..255, reset 84; mean converges on it at zero EV.
// - EV correction -2.00..+2.00 eV in quarter steps, reset 0, shifts the target.
// - Final target is target luminance times two to the EV correction.
// - Convergence band 0..50.00% of target, reset 1.00%; inside counts converged.
// - Narrower band gives a finer result but more frames to settle.
// - Feedback fraction 1..100%, reset 75%, scales every correction step.
// - Freeze bit, clear at reset, stops all exposure and gain corrections.
// - Exposure stays between floor and ceiling; software keeps floor below ceiling.
// - Exposure above the frame period may stretch frames, flagged on an output.
// - Exposure floor resets to the smallest exposure, ceiling to one frame period.
// - Gain stays between floor and ceiling, reset 0.00 and 18.00 dB.
// - Behaviour in random trigger shutter mode is not guaranteed.
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/100ps
module alc_loop #(
  parameter int FRAME_W = 640,
  parameter int FRAME_H = 480,
  parameter logic [23:0] EXP_MIN_US = 24'h00000a,
  parameter logic [23:0] FRAME_PERIOD_US = 24'h008235
) (
  input wire logic clk_i, // 125 MHz clock
  input wire logic nrst_i, // Async reset, active low
  input wire alc_pkg::alc_wb_req_s wb_req_i, // Wishbone request
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire alc_pkg::alc_pix_s pix_i, // Pixel stream and frame end
  input wire logic rts_mode_i, // Random trigger shutter active
  output logic [23:0] exposure_o, // Exposure time in us
  output logic [10:0] gain_o, // Gain in 0.01 dB
  output logic converged_o, // Last mean inside the band
  output logic frame_stretch_o, // Exposure longer than frame period
  output logic irq_o // Level interrupt
);
  import alc_pkg::*;

  localparam logic [11:0] MED_X0 = 12'(FRAME_W / 10);
  localparam logic [11:0] MED_X1 = 12'(FRAME_W - FRAME_W / 10);
  localparam logic [11:0] MED_Y0 = 12'(FRAME_H / 10);
  localparam logic [11:0] MED_Y1 = 12'(FRAME_H - FRAME_H / 10);
  localparam logic [11:0] SML_X0 = 12'(3 * FRAME_W / 10);
  localparam logic [11:0] SML_X1 = 12'(FRAME_W - 3 * FRAME_W / 10);
  localparam logic [11:0] SML_Y0 = 12'(3 * FRAME_H / 10);
  localparam logic [11:0] SML_Y1 = 12'(FRAME_H - 3 * FRAME_H / 10);

  logic en_reg, freeze_reg, ack_reg, conv_reg, brighten_reg, conv_pulse, state_pulse;
  logic [1:0] area_reg;
  logic [7:0] target_reg;
  logic signed [4:0] ev_reg;
  logic [12:0] band_reg;
  logic [13:0] frac_reg;
  logic [23:0] exp_floor_reg, exp_ceil_reg, exp_reg;
  logic [10:0] gain_floor_reg, gain_ceil_reg, gain_reg;
  logic [1:0] irq_stat_reg, irq_mask_reg;
  logic [31:0] rdat_reg;
  logic [9:0] mean_reg;
  logic [27:0] sum_reg;
  logic [23:0] cnt_reg;
  alc_state_e state_reg;
  logic [31:0] div_rem_reg, div_quo_reg, div_den_reg;
  logic [5:0] div_cnt_reg;

  // Byte-lane merge of a write into a 32-bit view of a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Bus: ack one cycle after the request, write lands on the edge that samples ack
  wire logic bus_req = wb_req_i.cyc && wb_req_i.stb;
  wire logic wr_go = bus_req && ack_reg && wb_req_i.we;
  wire logic rd_go = bus_req && ack_reg && !wb_req_i.we;
  wire logic [31:0] wdat = wb_req_i.dat;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req && !ack_reg;
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (wb_req_i.adr)
      OFS_CTRL: rd_mux = {30'h0, freeze_reg, en_reg};
      OFS_AREA: rd_mux = {30'h0, area_reg};
      OFS_TARGET: rd_mux = {24'h0, target_reg};
      OFS_EV: rd_mux = {{27{ev_reg[4]}}, ev_reg};
      OFS_BAND: rd_mux = {19'h0, band_reg};
      OFS_FRACTION: rd_mux = {18'h0, frac_reg};
      OFS_EXP_FLOOR: rd_mux = {8'h0, exp_floor_reg};
      OFS_EXP_CEIL: rd_mux = {8'h0, exp_ceil_reg};
      OFS_GAIN_FLOOR: rd_mux = {21'h0, gain_floor_reg};
      OFS_GAIN_CEIL: rd_mux = {21'h0, gain_ceil_reg};
      OFS_STATUS: rd_mux = {19'h0, state_reg, conv_reg, 10'h0} | {22'h0, mean_reg};
      OFS_EXPOSURE: rd_mux = {8'h0, exp_reg};
      OFS_GAIN: rd_mux = {21'h0, gain_reg};
      OFS_IRQ_STAT: rd_mux = {30'h0, irq_stat_reg};
      OFS_IRQ_MASK: rd_mux = {30'h0, irq_mask_reg};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdat_reg <= 32'h0;
    end else if (bus_req && !ack_reg) begin
      rdat_reg <= rd_mux;
    end
  end

  // Configuration writes, clamped to the legal ranges
  logic [31:0] wm;
  assign wm = merge(rd_mux, wdat, wb_req_i.sel);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en_reg <= 1'b0;
      freeze_reg <= 1'b0;
      area_reg <= AREA_FULL;
      target_reg <= TARGET_RST;
      ev_reg <= 5'sd0;
      band_reg <= BAND_RST;
      frac_reg <= FRAC_RST;
      exp_floor_reg <= EXP_MIN_US;
      exp_ceil_reg <= FRAME_PERIOD_US;
      gain_floor_reg <= GAIN_FLOOR_RST;
      gain_ceil_reg <= GAIN_CEIL_RST;
      irq_mask_reg <= 2'h0;
    end else if (wr_go) begin
      unique case (wb_req_i.adr)
        OFS_CTRL: begin
          en_reg <= wm[CTRL_EN_BIT];
          freeze_reg <= wm[CTRL_FREEZE_BIT];
        end
        OFS_AREA: area_reg <= (wm[1:0] == 2'h3) ? AREA_FULL : wm[1:0];
        OFS_TARGET: target_reg <= wm[7:0];
        OFS_EV: ev_reg <= ($signed(wm) < $signed({{27{EV_MIN[4]}}, EV_MIN})) ? EV_MIN
                          : ($signed(wm) > $signed({27'h0, EV_MAX})) ? EV_MAX : wm[4:0];
        OFS_BAND: band_reg <= (wm > {19'h0, BAND_MAX}) ? BAND_MAX : wm[12:0];
        OFS_FRACTION: frac_reg <= (wm < {18'h0, FRAC_MIN}) ? FRAC_MIN
                                  : (wm > {18'h0, FRAC_MAX}) ? FRAC_MAX : wm[13:0];
        OFS_EXP_FLOOR: exp_floor_reg <= wm[23:0];
        OFS_EXP_CEIL: exp_ceil_reg <= wm[23:0];
        OFS_GAIN_FLOOR: gain_floor_reg <= (wm > {21'h0, GAIN_CEIL_RST}) ? GAIN_CEIL_RST : wm[10:0];
        OFS_GAIN_CEIL: gain_ceil_reg <= (wm > {21'h0, GAIN_CEIL_RST}) ? GAIN_CEIL_RST : wm[10:0];
        OFS_IRQ_MASK: irq_mask_reg <= wm[1:0];
        default: ;
      endcase
    end
  end

  // Sticky events; a read clears only the bits it returned, so a late event is never lost
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_stat_reg <= 2'h0;
    end else begin
      irq_stat_reg <= ((rd_go && wb_req_i.adr == OFS_IRQ_STAT) ? irq_stat_reg & ~rdat_reg[1:0] : irq_stat_reg)
                      | {state_pulse, conv_pulse};
    end
  end

  // Metering: accumulate luminance inside the selected centred window
  logic in_area;
  always_comb begin
    unique case (area_reg)
      AREA_MEDIUM: in_area = pix_i.x >= MED_X0 && pix_i.x < MED_X1 && pix_i.y >= MED_Y0 && pix_i.y < MED_Y1;
      AREA_SMALL: in_area = pix_i.x >= SML_X0 && pix_i.x < SML_X1 && pix_i.y >= SML_Y0 && pix_i.y < SML_Y1;
      default: in_area = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sum_reg <= 28'h0;
      cnt_reg <= 24'h0;
    end else if (pix_i.frame_end) begin
      sum_reg <= 28'h0;
      cnt_reg <= 24'h0;
    end else if (pix_i.valid && in_area) begin
      sum_reg <= sum_reg + {20'h0, pix_i.luma};
      cnt_reg <= cnt_reg + 24'h1;
    end
  end

  // Target in quarter-luminance units: ref * 2^(ev/4), mantissa table in Q8
  logic [8:0] mant;
  logic signed [2:0] ev_int;
  logic [16:0] tgt_prod;
  logic [12:0] tgt_q2, band_q2, err_abs;
  logic in_band;
  always_comb begin
    ev_int = 3'(ev_reg >>> 2);
    unique case (ev_reg[1:0])
      2'h0: mant = 9'h100;
      2'h1: mant = 9'h130;
      2'h2: mant = 9'h16a;
      default: mant = 9'h1af;
    endcase
    tgt_prod = 17'(target_reg * mant);
    tgt_q2 = 13'(tgt_prod >> (6 - ev_int));
    band_q2 = 13'((40'(tgt_q2) * band_reg * INV_10K) >> INV_SHIFT);
    err_abs = (tgt_q2 > {3'h0, mean_reg}) ? tgt_q2 - {3'h0, mean_reg} : {3'h0, mean_reg} - tgt_q2;
    in_band = err_abs <= band_q2;
  end

  // Step size: ratio (Q8) times feedback fraction
  logic [15:0] ratio_q8;
  logic [16:0] step_q8;
  logic [23:0] exp_step;
  logic [10:0] gain_step;
  logic [24:0] exp_up;
  logic [11:0] gain_up;
  always_comb begin
    ratio_q8 = (div_quo_reg > 32'h0000ffff) ? 16'hffff : div_quo_reg[15:0];
    step_q8 = 17'((40'(ratio_q8) * frac_reg * INV_10K) >> INV_SHIFT);
    exp_step = 24'((41'(exp_reg) * step_q8) >> 8);
    if (exp_step == 24'h0) begin
      exp_step = 24'h1;
    end
    gain_step = ((27'(step_q8) * CDB_PER_LN) >> 8) > 27'h7ff ? 11'h7ff : 11'((27'(step_q8) * CDB_PER_LN) >> 8);
    if (gain_step == 11'h0) begin
      gain_step = 11'h1;
    end
    exp_up = {1'b0, exp_reg} + {1'b0, exp_step};
    gain_up = {1'b0, gain_reg} + {1'b0, gain_step};
  end

  // Loop sequencer: one measurement and at most one correction per frame
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= ST_IDLE;
      div_rem_reg <= 32'h0;
      div_quo_reg <= 32'h0;
      div_den_reg <= 32'h1;
      div_cnt_reg <= 6'h0;
      mean_reg <= 10'h0;
      conv_reg <= 1'b0;
      brighten_reg <= 1'b0;
      conv_pulse <= 1'b0;
      state_pulse <= 1'b0;
    end else begin
      conv_pulse <= 1'b0;
      state_pulse <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          // A frame ending mid-calculation is skipped rather than queued
          if (pix_i.frame_end && cnt_reg != 24'h0) begin
            div_rem_reg <= 32'h0;
            div_quo_reg <= {2'h0, sum_reg, 2'h0};
            div_den_reg <= {8'h0, cnt_reg};
            div_cnt_reg <= 6'(DIV_STEPS);
            state_reg <= ST_MEAN;
          end
        end
        ST_MEAN, ST_ERR: begin
          if (div_cnt_reg != 6'h0) begin
            if ({div_rem_reg, div_quo_reg[31]} >= {1'b0, div_den_reg}) begin
              div_rem_reg <= 32'({div_rem_reg, div_quo_reg[31]} - {1'b0, div_den_reg});
              div_quo_reg <= {div_quo_reg[30:0], 1'b1};
            end else begin
              div_rem_reg <= {div_rem_reg[30:0], div_quo_reg[31]};
              div_quo_reg <= {div_quo_reg[30:0], 1'b0};
            end
            div_cnt_reg <= div_cnt_reg - 6'h1;
          end else if (state_reg == ST_MEAN) begin
            mean_reg <= (div_quo_reg > 32'h3ff) ? 10'h3ff : div_quo_reg[9:0];
            state_reg <= ST_APPLY;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_APPLY: begin
          conv_reg <= in_band;
          conv_pulse <= in_band && !conv_reg;
          state_pulse <= 1'b1;
          brighten_reg <= tgt_q2 > {3'h0, mean_reg};
          // Random trigger mode is not detected; the loop just keeps running
          if (!in_band && en_reg && !freeze_reg && !rts_mode_i | rts_mode_i && en_reg && !freeze_reg && !in_band) begin
            div_rem_reg <= 32'h0;
            div_quo_reg <= {11'h0, err_abs, 8'h0};
            div_den_reg <= (mean_reg == 10'h0) ? 32'h1 : {22'h0, mean_reg};
            div_cnt_reg <= 6'(DIV_STEPS);
            state_reg <= ST_ERR;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Actuators: correction lands when the error division finishes
  wire logic apply_go = state_reg == ST_ERR && div_cnt_reg == 6'h0;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      exp_reg <= EXP_MIN_US;
      gain_reg <= GAIN_FLOOR_RST;
    end else if (apply_go) begin
      if (brighten_reg) begin
        if (exp_reg < exp_ceil_reg) begin
          exp_reg <= (exp_up > {1'b0, exp_ceil_reg}) ? exp_ceil_reg : exp_up[23:0];
        end else begin
          gain_reg <= (gain_up > {1'b0, gain_ceil_reg}) ? gain_ceil_reg : gain_up[10:0];
        end
      end else begin
        // Darkening unwinds gain first so exposure keeps priority
        if (gain_reg > gain_floor_reg) begin
          gain_reg <= (gain_reg - gain_floor_reg < gain_step) ? gain_floor_reg : gain_reg - gain_step;
        end else begin
          // Distance to the floor is compared, since floor plus step could wrap
          exp_reg <= (exp_reg <= exp_floor_reg || exp_reg - exp_floor_reg < exp_step) ? exp_floor_reg
                     : exp_reg - exp_step;
        end
      end
    end else if (state_reg == ST_IDLE) begin
      // Limits moved by software pull the outputs back inside
      if (exp_reg > exp_ceil_reg) begin
        exp_reg <= exp_ceil_reg;
      end else if (exp_reg < exp_floor_reg) begin
        exp_reg <= exp_floor_reg;
      end
      if (gain_reg > gain_ceil_reg) begin
        gain_reg <= gain_ceil_reg;
      end else if (gain_reg < gain_floor_reg) begin
        gain_reg <= gain_floor_reg;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      exposure_o <= EXP_MIN_US;
      gain_o <= GAIN_FLOOR_RST;
      converged_o <= 1'b0;
      frame_stretch_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      exposure_o <= exp_reg;
      gain_o <= gain_reg;
      converged_o <= conv_reg;
      frame_stretch_o <= exp_reg > FRAME_PERIOD_US;
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
endmodule

// ---- alc_pkg.sv ----
package alc_pkg;
  localparam int ADR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_AREA = 8'h04;
  localparam logic [7:0] OFS_TARGET = 8'h08;
  localparam logic [7:0] OFS_EV = 8'h0c;
  localparam logic [7:0] OFS_BAND = 8'h10;
  localparam logic [7:0] OFS_FRACTION = 8'h14;
  localparam logic [7:0] OFS_EXP_FLOOR = 8'h18;
  localparam logic [7:0] OFS_EXP_CEIL = 8'h1c;
  localparam logic [7:0] OFS_GAIN_FLOOR = 8'h20;
  localparam logic [7:0] OFS_GAIN_CEIL = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_EXPOSURE = 8'h2c;
  localparam logic [7:0] OFS_GAIN = 8'h30;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h34;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h38;
  // Field positions and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FREEZE_BIT = 1;
  localparam int IRQ_CONV_BIT = 0;
  localparam int IRQ_STATE_BIT = 1;
  localparam logic [1:0] AREA_FULL = 2'h0;
  localparam logic [1:0] AREA_MEDIUM = 2'h1;
  localparam logic [1:0] AREA_SMALL = 2'h2;
  localparam logic [7:0] TARGET_RST = 8'h54;
  localparam logic signed [4:0] EV_MIN = -5'sd8;
  localparam logic signed [4:0] EV_MAX = 5'sd8;
  localparam logic [12:0] BAND_RST = 13'h0064;
  localparam logic [12:0] BAND_MAX = 13'h1388;
  localparam logic [13:0] FRAC_RST = 14'h1d4c;
  localparam logic [13:0] FRAC_MIN = 14'h0064;
  localparam logic [13:0] FRAC_MAX = 14'h2710;
  localparam logic [10:0] GAIN_FLOOR_RST = 11'h000;
  localparam logic [10:0] GAIN_CEIL_RST = 11'h708;
  // Reciprocal of 10000 as 105 / 2^20, and centi-dB per unit of log ratio
  localparam logic [6:0] INV_10K = 7'h69;
  localparam int INV_SHIFT = 20;
  localparam logic [9:0] CDB_PER_LN = 10'h366;
  localparam int DIV_STEPS = 32;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEAN = 2'b01,
    ST_ERR = 2'b10,
    ST_APPLY = 2'b11
  } alc_state_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } alc_wb_req_s;

  typedef struct packed {
    logic valid;
    logic frame_end;
    logic [11:0] x;
    logic [11:0] y;
    logic [7:0] luma;
  } alc_pix_s;
endpackage

// ---- alc_sensor_model.sv ----
`timescale 1ns/100ps
module alc_sensor_model
  import alc_pkg::*;
#(
  parameter int W = 20,
  parameter int H = 10
) (
  input wire logic clk_i, // Clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic [23:0] exposure_i, // Exposure from the loop
  input wire logic [10:0] gain_i, // Gain from the loop
  input wire logic stretch_i, // Frame stretch flag
  input wire logic pattern_i, // Fixed area pattern instead of scene
  input wire logic [7:0] offset_i, // Scene brightness floor
  output alc_pkg::alc_pix_s pix_o // Pixel stream
);
  int cnt;

  // Pattern: bright core covering every reading of the small area, grey ring, dark top row and side columns
  function automatic logic [7:0] luma_at(input int x, input int y);
    int v;
    if (pattern_i) begin
      if (x >= 5 && x <= 14 && y >= 2 && y <= 8) v = 200;
      else if (x >= 1 && x <= 18 && y >= 1) v = 100;
      else v = 0;
    end else begin
      v = offset_i + exposure_i / 64 + gain_i / 32;
    end
    return (v > 255) ? 8'hff : v[7:0];
  endfunction

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= 0;
      pix_o <= '0;
    end else begin
      pix_o.valid <= (cnt < W * H);
      pix_o.frame_end <= (cnt == W * H);
      pix_o.x <= 12'(cnt % W);
      pix_o.y <= 12'(cnt / W);
      // Outside the frame the luma lines toggle so stale data never looks valid
      pix_o.luma <= (cnt < W * H) ? luma_at(cnt % W, cnt / W) : ~pix_o.luma;
      cnt <= (cnt >= W * H + (stretch_i ? 80 : 40)) ? 0 : cnt + 1;
    end
  end
endmodule

// ---- alc_loop_chk.sv ----
`timescale 1ns/100ps
module alc_loop_chk
  import alc_pkg::*;
#(
  parameter logic [23:0] EXP_MIN_US = 24'h00000a,
  parameter logic [23:0] FRAME_PERIOD_US = 24'h008235
) (
  input wire logic clk_i, // Clock
  input wire logic nrst_i, // Async reset, active low
  input wire alc_pkg::alc_wb_req_s wb_req_i, // Wishbone request
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire alc_pkg::alc_pix_s pix_i, // Pixel stream
  input wire logic rts_mode_i, // Random trigger mode
  input wire logic [23:0] exposure_o, // Exposure
  input wire logic [10:0] gain_o, // Gain
  input wire logic converged_o, // Converged level
  input wire logic frame_stretch_o, // Frame stretch flag
  input wire logic irq_o // Interrupt
);
  logic [7:0] since_fe_reg;
  logic [7:0] since_wr_reg;

  // Exposure and converged may only move shortly after a frame end; exposure also after a limit write clamps it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) since_fe_reg <= 8'hff;
    else if (pix_i.frame_end) since_fe_reg <= 8'h00;
    else if (since_fe_reg != 8'hff) since_fe_reg <= since_fe_reg + 8'h01;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) since_wr_reg <= 8'hff;
    else if (wb_ack_o && wb_req_i.we) since_wr_reg <= 8'h00;
    else if (since_wr_reg != 8'hff) since_wr_reg <= since_wr_reg + 8'h01;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_req_i.cyc) && $past(wb_req_i.stb))
    else $error("ack without request");
  a_unmapped_zero: assert property (wb_ack_o && !wb_req_i.we && wb_req_i.adr > 8'h38 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_exp_window: assert property ($changed(exposure_o) |-> since_fe_reg <= 8'd80 || since_wr_reg <= 8'd80)
    else $error("exposure moved outside a frame correction");
  a_conv_window: assert property ($changed(converged_o) |-> since_fe_reg <= 8'd80)
    else $error("converged moved outside a frame evaluation");
  a_stretch_flag: assert property ($stable(exposure_o) |-> frame_stretch_o == (exposure_o > FRAME_PERIOD_US))
    else $error("stretch flag disagrees with exposure");
  a_exp_floor: assert property (exposure_o >= EXP_MIN_US)
    else $error("exposure below smallest exposure");
  a_gain_ceiling: assert property (gain_o <= 11'h708)
    else $error("gain above ceiling");
  a_gain_order: assert property (gain_o > $past(gain_o) |-> exposure_o >= $past(exposure_o))
    else $error("gain raised while exposure lowered");
endmodule

bind alc_loop alc_loop_chk #(.EXP_MIN_US(EXP_MIN_US), .FRAME_PERIOD_US(FRAME_PERIOD_US)) alc_loop_chk_inst (
  .clk_i(clk_i), .nrst_i(nrst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pix_i(pix_i), .rts_mode_i(rts_mode_i), .exposure_o(exposure_o), .gain_o(gain_o),
  .converged_o(converged_o), .frame_stretch_o(frame_stretch_o), .irq_o(irq_o));

// ---- alc_loop_tb.sv ----
`timescale 1ns/100ps
module alc_loop_tb;
  import alc_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic pattern = 1'b1;
  logic [7:0] offset = 8'h14;
  logic rts_mode = 1'b0;
  alc_wb_req_s wb_req = '0;
  alc_pix_s pix;
  logic [31:0] wb_dat;
  logic [31:0] rd;
  logic [23:0] exposure;
  logic [23:0] exp_hold;
  logic [10:0] gain;
  logic [10:0] gain_hold;
  logic wb_ack;
  logic converged;
  logic stretch;
  logic irq;
  logic [9:0] am [3];
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [7:0] ra [10] = '{OFS_CTRL, OFS_AREA, OFS_TARGET, OFS_EV, OFS_BAND, OFS_FRACTION, OFS_EXP_FLOOR,
    OFS_EXP_CEIL, OFS_GAIN_FLOOR, OFS_GAIN_CEIL};
  logic [31:0] rv [10] = '{32'h0, 32'h0, 32'h54, 32'h0, 32'h64, 32'h1d4c, 32'ha, 32'h8235, 32'h0, 32'h708};
  logic [7:0] ca [8] = '{OFS_EV, OFS_EV, OFS_BAND, OFS_FRACTION, OFS_FRACTION, OFS_GAIN_CEIL, OFS_AREA, 8'h3c};
  logic [31:0] cw [8] = '{32'h14, 32'hffffffec, 32'h1770, 32'h0, 32'h4e20, 32'hbb8, 32'h3, 32'h5};
  logic [31:0] ce [8] = '{32'h8, 32'hfffffff8, 32'h1388, 32'h64, 32'h2710, 32'h708, 32'h0, 32'h0};

  alc_loop #(.FRAME_W(20), .FRAME_H(10)) alc_loop_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .pix_i(pix),
    .rts_mode_i(rts_mode), .exposure_o(exposure), .gain_o(gain), .converged_o(converged),
    .frame_stretch_o(stretch), .irq_o(irq));
  alc_sensor_model #(.W(20), .H(10)) alc_sensor_model_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .exposure_i(exposure), .gain_i(gain), .stretch_i(stretch), .pattern_i(pattern), .offset_i(offset), .pix_o(pix));

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One classic cycle; request held until ack is sampled, then idle for a cycle
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    rd = wb_dat;
    wb_req <= '0;
    @(posedge clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string what);
    xfer(1'b0, adr, 32'h0);
    check(rd, exp, what);
  endtask

  // The loop finishes about 70 cycles after a frame end
  task automatic frames(input int n);
    repeat (n) @(posedge pix.frame_end);
    repeat (100) @(posedge clk_i);
  endtask

  task automatic in_band(input int t, input int tol, input string what);
    xfer(1'b0, OFS_STATUS, 32'h0);
    check({31'h0, (rd[9:0] + tol >= t && rd[9:0] <= t + tol)}, 32'h1, what);
  endtask

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      $display("mismatch at %0t: timeout", $time);
      test_done();
    end
  end

  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    check({8'h0, exposure}, 32'ha, "exposure reset");
    check({21'h0, gain}, 32'h0, "gain reset");
    check({31'h0, irq}, 32'h0, "irq reset");
    for (int i = 0; i < 10; i++) rd_chk(ra[i], rv[i], "reset value");
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, ca[i], cw[i]);
      rd_chk(ca[i], ce[i], "clamped value");
    end
    xfer(1'b1, OFS_TARGET, 32'hff);
    rd_chk(OFS_TARGET, 32'hff, "target max");
    xfer(1'b1, OFS_TARGET, 32'h54);
    xfer(1'b1, OFS_EV, 32'h0);
    xfer(1'b1, OFS_FRACTION, 32'h1d4c);
    xfer(1'b1, OFS_BAND, 32'h1f4);
    for (int a = 0; a < 3; a++) begin
      xfer(1'b1, OFS_AREA, 32'(a));
      frames(2);
      xfer(1'b0, OFS_STATUS, 32'h0);
      am[a] = rd[9:0];
    end
    check({22'h0, am[0]}, 32'h1d0, "full area mean");
    check({22'h0, am[2]}, 32'h320, "small area mean");
    check({31'h0, (am[1] > am[0] && am[1] < am[2])}, 32'h1, "medium area mean");
    pattern <= 1'b0;
    xfer(1'b1, OFS_AREA, 32'h0);
    xfer(1'b1, OFS_IRQ_MASK, 32'h1);
    xfer(1'b0, OFS_IRQ_STAT, 32'h0);
    // Low ceiling forces the loop onto gain once exposure runs out
    xfer(1'b1, OFS_EXP_CEIL, 32'h3e8);
    xfer(1'b1, OFS_CTRL, 32'h1);
    frames(30);
    check({8'h0, exposure}, 32'h3e8, "exposure at ceiling");
    check({31'h0, (gain > 11'h0)}, 32'h1, "gain in use");
    check({31'h0, stretch}, 32'h0, "no frame stretch");
    in_band(336, 16, "mean at target");
    check({31'h0, converged}, 32'h1, "converged");
    check({31'h0, irq}, 32'h1, "convergence irq");
    xfer(1'b1, OFS_CTRL, 32'h3);
    xfer(1'b0, OFS_IRQ_STAT, 32'h0);
    check({31'h0, rd[0]}, 32'h1, "convergence event");
    repeat (2) @(posedge clk_i);
    check({31'h0, irq}, 32'h0, "irq cleared by read");
    exp_hold = exposure;
    gain_hold = gain;
    offset <= 8'h3c;
    frames(4);
    check({8'h0, exposure}, {8'h0, exp_hold}, "frozen exposure");
    check({21'h0, gain}, {21'h0, gain_hold}, "frozen gain");
    check({31'h0, converged}, 32'h0, "out of band");
    xfer(1'b0, OFS_IRQ_STAT, 32'h0);
    check({31'h0, rd[1]}, 32'h1, "state event");
    offset <= 8'h14;
    xfer(1'b1, OFS_EXP_CEIL, 32'h8235);
    xfer(1'b1, OFS_EV, 32'h4);
    rts_mode <= 1'b1;
    xfer(1'b1, OFS_CTRL, 32'h1);
    frames(40);
    in_band(672, 33, "mean at raised target");
    check({31'h0, converged}, 32'h1, "converged at raised target");
    test_done();
  end
endmodule
